// File: core/farc_defines.vh
`ifndef FARC_DEFINES_VH
`define FARC_DEFINES_VH

// ****************************************
// register byte addresses
// ****************************************
`define FARC_ADDR_MODE       8'h00
`define FARC_ADDR_UV_TIME    8'h04
`define FARC_ADDR_WAIT       8'h08
`define FARC_ADDR_UV_CFG     8'h0c
`define FARC_ADDR_FREQ_THR   8'h10
`define FARC_ADDR_OCOV_CNT   8'h14
`define FARC_ADDR_RETRY_WAIT 8'h18
`define FARC_ADDR_STATUS     8'h1c
`define FARC_ADDR_IRQ_STAT   8'h20
`define FARC_ADDR_IRQ_MASK   8'h24
`define FARC_ADDR_COUNTS     8'h28

// ****************************************
// codes and reset values
// ****************************************
`define FARC_MODE_ALARM      3'h0
`define FARC_MODE_ZERO       3'h1
`define FARC_MODE_MATCH      3'h2
`define FARC_MODE_MATCH_STOP 3'h3
`define FARC_MODE_ACTIVE     3'h4
`define FARC_UVA_OFF         2'h0
`define FARC_UVA_ON          2'h1
`define FARC_UVA_OFF_STOP    2'h2
`define FARC_OCOV_LIMIT_MAX  2'h3
`define FARC_OCOV_LIMIT_MIN  2'h1
`define FARC_UV_LIMIT        5'h10
// times kept in units of 0.1 s
`define FARC_T_MIN           10'h003
`define FARC_T_DEF           10'h00a
`define FARC_UV_T_MAX        10'h0fa
`define FARC_WAIT_T_MAX      10'h3e8
// frequency in units of 0.01 Hz; 400.0 Hz
`define FARC_FREQ_MAX        16'h9c40
`define FARC_TICK_NS         100000000
`define FARC_CLK_NS          10

// ****************************************
// axi responses, irq bits
// ****************************************
`define FARC_RESP_OKAY       2'h0
`define FARC_RESP_SLVERR     2'h2
`define FARC_IRQ_TRIP        0
`define FARC_IRQ_RESTART     1
`define FARC_IRQ_LOCKOUT     2
`define FARC_IRQ_UVALARM     3
`define FARC_IRQ_W           4

`endif

// File: core/farc_top.v
// Summary of operation
// - after an over-current trip at most 3 automatic restarts are made.
// - after an over-voltage trip at most 3 automatic restarts are made.
// - after an under-voltage trip at most 16 restarts are made when limited.
// - once a limit is reached the block stays tripped until power is cycled.
// - restart mode codes 0 alarm only, 1 zero hz, 2 match, 3 match then stop, 4 active match.
// - ride-through time 0.3 to 25.0 s, default 1.0; shorter dips do not trip.
// - under-voltage lasting past the ride-through trips whatever the mode.
// - a programmable delay of 0.3 to 100 s, default 1.0, precedes each restart.
// - under-voltage alarm codes 0 off, 1 on, 2 off while stopped or stopping.
// - under-voltage count code 0 limits restarts to 16, code 1 is unlimited.
// - phase-loss code 0 gives no trip, code 1 trips on phase loss.
// - a restart threshold of 0.00 to 400.0 Hz is compared with motor speed.
// - retry style codes 1 to 4 mirror the restart styles; code 0 uses the restart mode code.
// - the over-current/over-voltage retry count is 1 to 3, default 3.
// - the wait between trip and retry is 0.3 to 100.0 s, default 1.0.
// - matching modes start output at the flux-estimated motor frequency.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "farc_defines.vh"

module farc_top #(
   parameter TICK_CYCLES = `FARC_TICK_NS / `FARC_CLK_NS
) (
   input wire clk,                    // system clock, 100 MHz
   input wire sys_rst,                // sync reset, power cycle
   input wire [7:0] s_axi_awaddr,     // write address
   input wire s_axi_awvalid,          // write address valid
   output wire s_axi_awready,         // write address ready
   input wire [31:0] s_axi_wdata,     // write data
   input wire [3:0] s_axi_wstrb,      // write strobes
   input wire s_axi_wvalid,           // write data valid
   output wire s_axi_wready,          // write data ready
   output reg [1:0] s_axi_bresp,      // write response
   output reg s_axi_bvalid,           // write response valid
   input wire s_axi_bready,           // write response ready
   input wire [7:0] s_axi_araddr,     // read address
   input wire s_axi_arvalid,          // read address valid
   output wire s_axi_arready,         // read address ready
   output reg [31:0] s_axi_rdata,     // read data
   output reg [1:0] s_axi_rresp,      // read response
   output reg s_axi_rvalid,           // read valid
   input wire s_axi_rready,           // read ready
   input wire oc_fault,               // over-current level
   input wire ov_fault,               // over-voltage level
   input wire uv_fault,               // under-voltage level
   input wire phase_loss,             // input phase lost
   input wire run_cmd,                // operator run request
   input wire stopping,               // stopped or ramping to stop
   input wire [15:0] motor_freq,      // flux estimate, 0.01 Hz
   output reg drive_enable,           // power stage output on
   output reg [15:0] start_freq,      // start frequency, 0.01 Hz
   output reg decel_to_stop,          // ramp down after match
   output reg trip_out,               // tripped indication
   output reg lockout,                // retries exhausted
   output reg uv_alarm,               // under-voltage alarm
   output wire irq                    // level interrupt
);

   // ****************************************
   // state machine codes
   // ****************************************
   localparam ST_IDLE = 3'd0;
   localparam ST_RUN = 3'd1;
   localparam ST_WAIT = 3'd2;
   localparam ST_TRIP = 3'd3;
   localparam ST_LOCK = 3'd4;

   localparam CAUSE_OC = 2'd0;
   localparam CAUSE_OV = 2'd1;
   localparam CAUSE_UV = 2'd2;

   // ****************************************
   // configuration registers
   // ****************************************
   reg [2:0] restart_mode_select_reg;
   reg [9:0] undervoltage_ride_through_time_reg;
   reg [9:0] restart_wait_time_reg;
   reg [1:0] undervoltage_alarm_enable_reg;
   reg undervoltage_restart_count_reg;
   reg phase_loss_detect_enable_reg;
   reg [15:0] restart_freq_threshold_reg;
   reg [2:0] retry_style_select_reg;
   reg [1:0] overcurrent_overvoltage_retry_count_reg;
   reg [9:0] retry_wait_after_trip_reg;
   reg [`FARC_IRQ_W-1:0] irq_stat_reg;
   reg [`FARC_IRQ_W-1:0] irq_mask_reg;

   reg [2:0] state_reg;
   reg [1:0] cause_reg;
   reg [1:0] oc_cnt_reg;
   reg [1:0] ov_cnt_reg;
   reg [4:0] uv_cnt_reg;
   reg [31:0] tick_cnt_reg;
   reg [9:0] tenth_cnt_reg;
   reg [9:0] uv_time_reg;
   reg [`FARC_IRQ_W-1:0] ev;

   // ****************************************
   // helpers
   // ****************************************
   // whole word compared so oversize writes saturate instead of wrapping
   function [9:0] clamp_time;
      input [31:0] v;
      input [9:0] vmax;
      begin
         if (v < `FARC_T_MIN)
            clamp_time = `FARC_T_MIN;
         else if (v > vmax)
            clamp_time = vmax;
         else
            clamp_time = v[9:0];
      end
   endfunction

   function [1:0] clamp_cnt;
      input [31:0] v;
      begin
         if (v < `FARC_OCOV_LIMIT_MIN)
            clamp_cnt = `FARC_OCOV_LIMIT_MIN;
         else if (v > `FARC_OCOV_LIMIT_MAX)
            clamp_cnt = `FARC_OCOV_LIMIT_MAX;
         else
            clamp_cnt = v[1:0];
      end
   endfunction

   function is_match_mode;
      input [2:0] m;
      begin
         is_match_mode = (m == `FARC_MODE_MATCH) || (m == `FARC_MODE_MATCH_STOP) ||
            (m == `FARC_MODE_ACTIVE);
      end
   endfunction

   // ****************************************
   // axi4-lite slave
   // ****************************************
   wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = !s_axi_rvalid;
   wire rd_go = s_axi_arvalid && !s_axi_rvalid;
   wire wr_full = s_axi_wstrb == 4'hf;
   // partial writes are ignored; every field is written whole
   wire wr_en = wr_go && wr_full;

   wire wr_known = (s_axi_awaddr <= `FARC_ADDR_COUNTS) && (s_axi_awaddr[1:0] == 2'b00);
   wire rd_known = (s_axi_araddr <= `FARC_ADDR_COUNTS) && (s_axi_araddr[1:0] == 2'b00);

   always @(posedge clk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FARC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_known ? `FARC_RESP_OKAY : `FARC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always @(posedge clk) begin
      if (sys_rst) begin
         restart_mode_select_reg <= `FARC_MODE_ALARM;
         undervoltage_ride_through_time_reg <= `FARC_T_DEF;
         restart_wait_time_reg <= `FARC_T_DEF;
         undervoltage_alarm_enable_reg <= `FARC_UVA_OFF;
         undervoltage_restart_count_reg <= 1'b0;
         phase_loss_detect_enable_reg <= 1'b0;
         restart_freq_threshold_reg <= 16'h0000;
         retry_style_select_reg <= `FARC_MODE_ALARM;
         overcurrent_overvoltage_retry_count_reg <= `FARC_OCOV_LIMIT_MAX;
         retry_wait_after_trip_reg <= `FARC_T_DEF;
         irq_mask_reg <= {`FARC_IRQ_W{1'b0}};
      end else if (wr_en) begin
         case (s_axi_awaddr)
            `FARC_ADDR_MODE: begin
               if (s_axi_wdata[2:0] <= `FARC_MODE_ACTIVE)
                  restart_mode_select_reg <= s_axi_wdata[2:0];
               if (s_axi_wdata[10:8] <= `FARC_MODE_ACTIVE)
                  retry_style_select_reg <= s_axi_wdata[10:8];
            end
            `FARC_ADDR_UV_TIME: undervoltage_ride_through_time_reg <=
               clamp_time(s_axi_wdata, `FARC_UV_T_MAX);
            `FARC_ADDR_WAIT: restart_wait_time_reg <=
               clamp_time(s_axi_wdata, `FARC_WAIT_T_MAX);
            `FARC_ADDR_UV_CFG: begin
               if (s_axi_wdata[1:0] <= `FARC_UVA_OFF_STOP)
                  undervoltage_alarm_enable_reg <= s_axi_wdata[1:0];
               undervoltage_restart_count_reg <= s_axi_wdata[8];
               phase_loss_detect_enable_reg <= s_axi_wdata[16];
            end
            `FARC_ADDR_FREQ_THR: restart_freq_threshold_reg <=
               (s_axi_wdata > {16'h0000, `FARC_FREQ_MAX}) ? `FARC_FREQ_MAX :
               s_axi_wdata[15:0];
            `FARC_ADDR_OCOV_CNT: overcurrent_overvoltage_retry_count_reg <=
               clamp_cnt(s_axi_wdata);
            `FARC_ADDR_RETRY_WAIT: retry_wait_after_trip_reg <=
               clamp_time(s_axi_wdata, `FARC_WAIT_T_MAX);
            `FARC_ADDR_IRQ_MASK: irq_mask_reg <= s_axi_wdata[`FARC_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // sticky status: a new event wins over a write-one clear
   always @(posedge clk) begin
      if (sys_rst)
         irq_stat_reg <= {`FARC_IRQ_W{1'b0}};
      else if (wr_en && s_axi_awaddr == `FARC_ADDR_IRQ_STAT)
         irq_stat_reg <= (irq_stat_reg & ~s_axi_wdata[`FARC_IRQ_W-1:0]) | ev;
      else
         irq_stat_reg <= irq_stat_reg | ev;
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always @(posedge clk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `FARC_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= rd_known ? `FARC_RESP_OKAY : `FARC_RESP_SLVERR;
         case (s_axi_araddr)
            `FARC_ADDR_MODE: s_axi_rdata <= {21'h0, retry_style_select_reg, 5'h0,
               restart_mode_select_reg};
            `FARC_ADDR_UV_TIME: s_axi_rdata <= {22'h0, undervoltage_ride_through_time_reg};
            `FARC_ADDR_WAIT: s_axi_rdata <= {22'h0, restart_wait_time_reg};
            `FARC_ADDR_UV_CFG: s_axi_rdata <= {15'h0, phase_loss_detect_enable_reg, 7'h0,
               undervoltage_restart_count_reg, 6'h0, undervoltage_alarm_enable_reg};
            `FARC_ADDR_FREQ_THR: s_axi_rdata <= {16'h0, restart_freq_threshold_reg};
            `FARC_ADDR_OCOV_CNT: s_axi_rdata <= {30'h0, overcurrent_overvoltage_retry_count_reg};
            `FARC_ADDR_RETRY_WAIT: s_axi_rdata <= {22'h0, retry_wait_after_trip_reg};
            `FARC_ADDR_STATUS: s_axi_rdata <= {27'h0, cause_reg, state_reg};
            `FARC_ADDR_IRQ_STAT: s_axi_rdata <= {28'h0, irq_stat_reg};
            `FARC_ADDR_IRQ_MASK: s_axi_rdata <= {28'h0, irq_mask_reg};
            `FARC_ADDR_COUNTS: s_axi_rdata <= {16'h0, 3'h0, uv_cnt_reg, 2'h0, ov_cnt_reg,
               2'h0, oc_cnt_reg};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // 0.1 s time base
   // ****************************************
   wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
   always @(posedge clk) begin
      if (sys_rst || tick)
         tick_cnt_reg <= 32'h00000000;
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
   end

   // ride-through: dips shorter than the set time are forgiven
   wire uv_expired = uv_time_reg >= undervoltage_ride_through_time_reg;
   always @(posedge clk) begin
      if (sys_rst || !uv_fault)
         uv_time_reg <= 10'h000;
      else if (tick && !uv_expired)
         uv_time_reg <= uv_time_reg + 10'h001;
   end

   // ****************************************
   // restart policy
   // ****************************************
   wire pl_trip = phase_loss && phase_loss_detect_enable_reg;
   wire uv_trip = uv_fault && uv_expired;
   wire any_trip = oc_fault || ov_fault || uv_trip || pl_trip;
   wire [1:0] new_cause = oc_fault ? CAUSE_OC : (ov_fault ? CAUSE_OV : CAUSE_UV);
   wire oc_done = oc_cnt_reg >= overcurrent_overvoltage_retry_count_reg;
   wire ov_done = ov_cnt_reg >= overcurrent_overvoltage_retry_count_reg;
   wire uv_done = !undervoltage_restart_count_reg && (uv_cnt_reg >= `FARC_UV_LIMIT);
   // phase loss has no retry budget; it goes straight to a held trip
   wire no_retry = pl_trip || (restart_mode_select_reg == `FARC_MODE_ALARM) ||
      (new_cause == CAUSE_OC && oc_done) || (new_cause == CAUSE_OV && ov_done) ||
      (new_cause == CAUSE_UV && uv_done);
   // wait between retries: operator wait and after-trip wait, longer wins
   wire [9:0] wait_t = (restart_wait_time_reg > retry_wait_after_trip_reg) ?
      restart_wait_time_reg : retry_wait_after_trip_reg;
   wire [2:0] style = (retry_style_select_reg != `FARC_MODE_ALARM) ?
      retry_style_select_reg : restart_mode_select_reg;

   always @(posedge clk) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         cause_reg <= CAUSE_OC;
         oc_cnt_reg <= 2'h0;
         ov_cnt_reg <= 2'h0;
         uv_cnt_reg <= 5'h00;
         tenth_cnt_reg <= 10'h000;
         drive_enable <= 1'b0;
         start_freq <= 16'h0000;
         decel_to_stop <= 1'b0;
         trip_out <= 1'b0;
         lockout <= 1'b0;
         ev <= {`FARC_IRQ_W{1'b0}};
      end else begin
         ev <= {`FARC_IRQ_W{1'b0}};
         case (state_reg)
            ST_IDLE: begin
               if (run_cmd && !any_trip) begin
                  state_reg <= ST_RUN;
                  drive_enable <= 1'b1;
                  start_freq <= 16'h0000;
                  decel_to_stop <= 1'b0;
               end
            end
            ST_RUN: begin
               if (any_trip) begin
                  drive_enable <= 1'b0;
                  trip_out <= 1'b1;
                  cause_reg <= new_cause;
                  ev[`FARC_IRQ_TRIP] <= 1'b1;
                  tenth_cnt_reg <= 10'h000;
                  if (no_retry) begin
                     state_reg <= (restart_mode_select_reg == `FARC_MODE_ALARM && !pl_trip) ?
                        ST_TRIP : ST_LOCK;
                     lockout <= restart_mode_select_reg != `FARC_MODE_ALARM || pl_trip;
                     ev[`FARC_IRQ_LOCKOUT] <= 1'b1;
                  end else begin
                     state_reg <= ST_WAIT;
                     if (new_cause == CAUSE_OC)
                        oc_cnt_reg <= oc_cnt_reg + 2'h1;
                     else if (new_cause == CAUSE_OV)
                        ov_cnt_reg <= ov_cnt_reg + 2'h1;
                     else if (uv_cnt_reg != 5'h1f)
                        uv_cnt_reg <= uv_cnt_reg + 5'h01;
                  end
               end else if (!run_cmd) begin
                  state_reg <= ST_IDLE;
                  drive_enable <= 1'b0;
               end
            end
            ST_WAIT: begin
               if (tick)
                  tenth_cnt_reg <= tenth_cnt_reg + 10'h001;
               if (tenth_cnt_reg >= wait_t && !any_trip) begin
                  state_reg <= ST_RUN;
                  drive_enable <= 1'b1;
                  trip_out <= 1'b0;
                  ev[`FARC_IRQ_RESTART] <= 1'b1;
                  // below threshold the motor is treated as stopped
                  if (is_match_mode(style) && motor_freq >= restart_freq_threshold_reg)
                     start_freq <= motor_freq;
                  else
                     start_freq <= 16'h0000;
                  decel_to_stop <= style == `FARC_MODE_MATCH_STOP;
               end
            end
            ST_TRIP: begin
               // alarm-only trip: operator clears it by dropping run
               if (!run_cmd && !any_trip) begin
                  state_reg <= ST_IDLE;
                  trip_out <= 1'b0;
               end
            end
            ST_LOCK: begin
               drive_enable <= 1'b0;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // under-voltage alarm
   // ****************************************
   always @(posedge clk) begin
      if (sys_rst)
         uv_alarm <= 1'b0;
      else
         case (undervoltage_alarm_enable_reg)
            `FARC_UVA_ON: uv_alarm <= uv_trip;
            `FARC_UVA_OFF_STOP: uv_alarm <= uv_trip && !stopping;
            default: uv_alarm <= 1'b0;
         endcase
   end

endmodule

// File: test/farc_top_assertions.sv
`timescale 1ns/1ps
// ****************************************
// port checks for the restart controller
// ****************************************
module farc_top_assertions (
   input logic clk, // clock
   input logic sys_rst, // sync reset
   input logic s_axi_awvalid, // aw valid
   input logic s_axi_awready, // aw ready
   input logic s_axi_bvalid, // b valid
   input logic s_axi_arvalid, // ar valid
   input logic s_axi_arready, // ar ready
   input logic s_axi_rvalid, // r valid
   input logic oc_fault, // over-current
   input logic ov_fault, // over-voltage
   input logic drive_enable, // output on
   input logic trip_out, // tripped
   input logic lockout // retries spent
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_oc_trip: assert property (drive_enable && oc_fault |=> !drive_enable && trip_out)
      else $error("over-current did not stop the drive");
   chk_ov_trip: assert property (drive_enable && ov_fault |=> !drive_enable && trip_out)
      else $error("over-voltage did not stop the drive");
   chk_trip_off: assert property (trip_out |-> !drive_enable)
      else $error("drive on while tripped");
   chk_lock_hold: assert property (lockout |=> lockout)
      else $error("lockout left without reset");
   chk_lock_off: assert property (lockout |-> !drive_enable)
      else $error("drive on during lockout");
   // the shortest wait is three ticks, so eight cycles is always safe
   chk_no_quick: assert property ($fell(drive_enable) && trip_out |=> !drive_enable [*8])
      else $error("restart without delay");
   chk_reset_clear: assert property ($fell(sys_rst) |-> !drive_enable && !lockout && !trip_out)
      else $error("state survived reset");
   chk_write_resp: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
      else $error("write response missing");
   chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
endmodule

bind farc_top farc_top_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .oc_fault(oc_fault), .ov_fault(ov_fault), .drive_enable(drive_enable),
   .trip_out(trip_out), .lockout(lockout));

// File: test/farc_motor_model.sv
`timescale 1ns/1ps
// ****************************************
// motor and power stage stand-in
// ****************************************
module farc_motor_model (
   input logic clk, // clock
   input logic [3:0] fault_req, // bench fault pattern
   input logic [15:0] coast_freq, // spin-down speed
   input logic drive_enable, // stage on
   input logic [15:0] start_freq, // commanded start
   output logic oc_fault, // over-current
   output logic ov_fault, // over-voltage
   output logic uv_fault, // under-voltage
   output logic phase_loss, // input phase lost
   output logic [15:0] motor_freq // flux speed estimate
);
   initial begin
      {phase_loss, uv_fault, ov_fault, oc_fault} = 4'h0;
      motor_freq = 16'h0;
   end
   always @(posedge clk) begin
      {phase_loss, uv_fault, ov_fault, oc_fault} <= fault_req;
      // a free rotor keeps its flux only while the stage is off
      motor_freq <= drive_enable ? start_freq : coast_freq;
   end
endmodule

// File: test/tb_fault_auto_restart_control.sv
`timescale 1ns/1ps
module tb_fault_auto_restart_control;
   logic clk = 1'h0, sys_rst = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, run_cmd = 1'h0, stop_in = 1'h0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] fault_req = 4'h0;
   logic [15:0] coast_freq = 16'h07d0;
   wire awready, wready, bvalid, arready, rvalid, oc, ov, uv, pl, de, dts, tout, lock, uva, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [15:0] sfreq, mfreq;
   integer err_total = 0, total_checks = 0, i;
   logic [31:0] dv [0:10] = '{32'h0, 32'ha, 32'ha, 32'h0, 32'h0, 32'h3, 32'ha, 32'h0, 32'h0,
      32'h0, 32'h0};

   always #5 clk = ~clk;

   farc_top #(.TICK_CYCLES(10)) dut (.clk(clk), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .oc_fault(oc), .ov_fault(ov), .uv_fault(uv), .phase_loss(pl), .run_cmd(run_cmd),
      .stopping(stop_in), .motor_freq(mfreq), .drive_enable(de), .start_freq(sfreq),
      .decel_to_stop(dts), .trip_out(tout), .lockout(lock), .uv_alarm(uva), .irq(irq));

   farc_motor_model partner (.clk(clk), .fault_req(fault_req), .coast_freq(coast_freq),
      .drive_enable(de), .start_freq(sfreq), .oc_fault(oc), .ov_fault(ov), .uv_fault(uv),
      .phase_loss(pl), .motor_freq(mfreq));

   // ****************************************
   // access tasks
   // ****************************************
   task chk(input string n, input [31:0] e, input [31:0] g);
      begin
         total_checks++;
         if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
         end
      end
   endtask

   task axi_wr(input [7:0] a, input [31:0] d, input [1:0] er);
      begin
         @(posedge clk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
         do @(posedge clk); while (awready !== 1'h1);
         awvalid <= 1'h0;
         wvalid <= 1'h0;
         do @(posedge clk); while (bvalid !== 1'h1);
         bready <= 1'h0;
         chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      axi_wr(a, d, 2'h0);
   endtask

   task rd(input [7:0] a, input [31:0] e, input [1:0] er);
      begin
         @(posedge clk);
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
         do @(posedge clk); while (arready !== 1'h1);
         arvalid <= 1'h0;
         do @(posedge clk); while (rvalid !== 1'h1);
         rready <= 1'h0;
         chk("rdata", e, rdata);
         chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
   endtask

   task pulse(input [3:0] k, input integer n);
      begin
         fault_req <= k;
         repeat (n) @(posedge clk);
         fault_req <= 4'h0;
         @(posedge clk);
      end
   endtask

   task wait_de(input logic v, input integer n);
      integer c;
      begin
         c = 0;
         while (de !== v && c < n) begin
            @(posedge clk);
            c++;
         end
         chk("drive_enable", {31'h0, v}, {31'h0, de});
      end
   endtask

   // short waits and ride-through so each trip costs a few dozen cycles
   task rst_cfg(input [31:0] m, input [31:0] u);
      begin
         run_cmd <= 1'h0;
         sys_rst <= 1'h1;
         repeat (2) @(posedge clk);
         sys_rst <= 1'h0;
         wr(8'h00, m);
         wr(8'h04, 32'h3);
         wr(8'h08, 32'h3);
         wr(8'h18, 32'h3);
         wr(8'h0c, u);
         wr(8'h24, 32'h7);
         run_cmd <= 1'h1;
         wait_de(1'h1, 50);
      end
   endtask

   task close_out;
      begin
         $display("checks %0d mismatches %0d", total_checks, err_total);
         if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial begin
      // whole run needs a few thousand cycles
      #300000;
      err_total++;
      close_out;
   end

   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'h0;
      for (i = 0; i < 11; i++) rd(8'(i * 4), dv[i], 2'h0);
      rd(8'h2c, 32'h0, 2'h2);
      axi_wr(8'h2c, 32'h1, 2'h2);
      wr(8'h04, 32'h1);
      rd(8'h04, 32'h3, 2'h0);
      wr(8'h08, 32'h7d0);
      rd(8'h08, 32'h3e8, 2'h0);
      wr(8'h14, 32'h0);
      rd(8'h14, 32'h1, 2'h0);
      rst_cfg(32'h1, 32'h0);
      pulse(4'h4, 5);
      chk("drive_enable", 1, de);
      pulse(4'h8, 5);
      chk("drive_enable", 1, de);
      pulse(4'h4, 80);
      chk("drive_enable", 0, de);
      chk("uv_alarm", 32'h0, uva);
      wait_de(1'h1, 200);
      wr(8'h0c, 32'h2);
      stop_in <= 1'h1;
      pulse(4'h4, 80);
      chk("uv_alarm", 32'h0, uva);
      wait_de(1'h1, 200);
      rd(8'h28, 32'h200, 2'h0);
      for (i = 0; i < 4; i++) begin
         pulse(4'h1, 3);
         chk("drive_enable", 0, de);
         if (i < 3) begin
            wait_de(1'h1, 200);
            chk("start_freq", 0, sfreq);
         end
      end
      chk("lockout", 1, lock);
      chk("irq", 1, irq);
      rd(8'h28, 32'h203, 2'h0);
      wr(8'h20, 32'h7);
      chk("irq", 0, irq);
      repeat (100) @(posedge clk);
      chk("lockout", 1, lock);
      rd(8'h1c, 32'h4, 2'h0);
      rst_cfg(32'h302, 32'h0);
      wr(8'h10, 32'h3e8);
      pulse(4'h2, 3);
      wait_de(1'h1, 200);
      chk("start_freq", 32'h7d0, sfreq);
      chk("decel_to_stop", 1, dts);
      wr(8'h10, 32'hbb8);
      pulse(4'h2, 3);
      wait_de(1'h1, 200);
      chk("start_freq", 0, sfreq);
      rd(8'h28, 32'h20, 2'h0);
      rst_cfg(32'h4, 32'h0);
      pulse(4'h1, 3);
      wait_de(1'h1, 200);
      chk("start_freq", 32'h7d0, sfreq);
      rst_cfg(32'h0, 32'h0);
      pulse(4'h1, 3);
      repeat (100) @(posedge clk);
      chk("drive_enable", 0, de);
      chk("trip_out", 1, tout);
      rd(8'h1c, 32'h3, 2'h0);
      rst_cfg(32'h1, 32'h0);
      for (i = 0; i < 17; i++) begin
         pulse(4'h4, 50);
         if (i < 16) wait_de(1'h1, 200);
      end
      chk("lockout", 32'h1, lock);
      rd(8'h28, 32'h1000, 2'h0);
      rst_cfg(32'h1, 32'h10101);
      for (i = 0; i < 17; i++) begin
         pulse(4'h4, 50);
         chk("uv_alarm", 32'h1, uva);
         wait_de(1'h1, 200);
      end
      pulse(4'h8, 3);
      chk("lockout", 1, lock);
      close_out;
   end
endmodule
